// file: design/charger_option_hot_alert_regs.sv
// Charge option low byte and processor-hot option register pair, with the
// threshold comparators and deglitch timers that these settings steer.
// Assumes an I2C engine on clk_sys presents one byte access per request and
// that measured current and voltage come from ADC logic on the same clock.
// The cell count and assist mode inputs are pins and pass a synchroniser.
//
// Functional notes
// - Bit 6 enables conservative assist, reset off.
// - Bit 5 selects external pin role, reset 1.
// - Bits 4-3 clamp inductor current, reset 15A.
// - Bit 2 selects reverse-supply voltage range.
// - Bit 1 turns battery switch off in high-impedance.
// - Bit 0 picks power monitor source.
// - Codes 1-25 map 110-230 percent, 5 step.
// - Codes 26-30 map 250-450 percent; 31 ignored.
// - Trip above threshold; field resets to 150 percent.
// - Critical threshold is 110 percent of secondary.
// - Deglitch field picks 15/120/500/1000 microseconds.
// - Lower threshold bit picks 80 or 90 percent.
// - System threshold one triggers bus discharge, 5us deglitch.
// - Multi-cell codes map 5.9 to 7.4 volts.
// - Single-cell codes wrap 3.1 to 3.8 volts.
// - Lower enable bit selects follow or lower threshold.
`timescale 1ns/100ps
`default_nettype none
module charger_option_hot_alert_regs
  import charger_option_pkg::*;
#(
  parameter int CRIT_DEG_120US = CRIT_DEG_120US_CYCLES,
  parameter int CRIT_DEG_500US = CRIT_DEG_500US_CYCLES,
  parameter int CRIT_DEG_1MS = CRIT_DEG_1MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  input wire logic [11:0] input_current_pct,
  input wire logic [15:0] system_voltage_mv,
  input wire logic single_cell,
  input wire logic min_voltage_assist_mode,
  output var charge_cfg_s charge_cfg,
  output logic secondary_limit_trip,
  output logic critical_current_trip,
  output logic processor_hot_alert,
  output logic [6:0] input_voltage_alert_pct,
  output logic [15:0] system_threshold_mv,
  output logic input_bus_discharge
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] charge_option_three_low;
  logic [15:0] hot_alert_option_zero;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      charge_option_three_low <= CHARGE_OPTION_THREE_LOW_RESET;
    end
    else if (req.write && req.addr == CHARGE_OPTION_THREE_LOW_ADDR)
    begin
      charge_option_three_low <= req.wdata;
    end
  end

  // Each byte has its own enable so a write never disturbs its partner.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      hot_alert_option_zero <= HOT_ALERT_OPTION_ZERO_RESET;
    end
    else if (req.write && req.addr == HOT_ALERT_OPTION_ZERO_LO_ADDR)
    begin
      hot_alert_option_zero[7:0] <= req.wdata;
    end
    else if (req.write && req.addr == HOT_ALERT_OPTION_ZERO_HI_ADDR)
    begin
      hot_alert_option_zero[15:8] <= req.wdata;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] next_rdata;

  always_comb
  begin
    case (req.addr)
      CHARGE_OPTION_THREE_LOW_ADDR: next_rdata = charge_option_three_low;
      HOT_ALERT_OPTION_ZERO_LO_ADDR: next_rdata = hot_alert_option_zero[7:0];
      HOT_ALERT_OPTION_ZERO_HI_ADDR: next_rdata = hot_alert_option_zero[15:8];
      default: next_rdata = UNMAPPED_READ_VALUE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= req.read;
      if (req.read)
      begin
        rdata <= next_rdata;
      end
    end
  end

  // ****************************************************************
  // Charge configuration outputs
  // ****************************************************************
  always_comb
  begin
    charge_cfg.conservative_assist_enable =
      charge_option_three_low[CONSERVATIVE_ASSIST_ENABLE_BIT];
    charge_cfg.external_pin_role_select =
      charge_option_three_low[EXTERNAL_PIN_ROLE_SELECT_BIT];
    charge_cfg.inductor_avg_clamp = inductor_clamp_e'(
      charge_option_three_low[INDUCTOR_AVG_CLAMP_MSB:INDUCTOR_AVG_CLAMP_LSB]);
    charge_cfg.reverse_supply_low_range =
      charge_option_three_low[REVERSE_SUPPLY_LOW_RANGE_BIT];
    charge_cfg.battery_switch_off_in_highz =
      charge_option_three_low[BATTERY_SWITCH_OFF_IN_HIGHZ_BIT];
    charge_cfg.power_monitor_source_select =
      charge_option_three_low[POWER_MONITOR_SOURCE_SELECT_BIT];
  end

  // ****************************************************************
  // Input current comparators
  // ****************************************************************
  logic limit_valid;
  logic [11:0] limit_pct;
  logic [11:0] critical_pct;

  input_limit_decode u_limit_decode (
    .code(hot_alert_option_zero[SECONDARY_INPUT_LIMIT_MSB:SECONDARY_INPUT_LIMIT_LSB]),
    .valid(limit_valid),
    .limit_pct(limit_pct),
    .critical_pct(critical_pct)
  );

  // An out-of-range code disables both comparisons rather than tripping.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      secondary_limit_trip <= 1'b0;
      critical_current_trip <= 1'b0;
    end
    else
    begin
      secondary_limit_trip <= limit_valid && (input_current_pct > limit_pct);
      critical_current_trip <= limit_valid && (input_current_pct > critical_pct);
    end
  end

  logic [DEGLITCH_COUNT_W-1:0] crit_hold;

  always_comb
  begin
    case (hot_alert_option_zero[CRITICAL_CURRENT_DEGLITCH_MSB:CRITICAL_CURRENT_DEGLITCH_LSB])
      2'b00: crit_hold = DEGLITCH_COUNT_W'(CRIT_DEG_15US_CYCLES);
      2'b01: crit_hold = DEGLITCH_COUNT_W'(CRIT_DEG_120US);
      2'b10: crit_hold = DEGLITCH_COUNT_W'(CRIT_DEG_500US);
      default: crit_hold = DEGLITCH_COUNT_W'(CRIT_DEG_1MS);
    endcase
  end

  deglitch_timer u_critical_deglitch (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(critical_current_trip),
    .hold_cycles(crit_hold),
    .qualified(processor_hot_alert)
  );

  // ****************************************************************
  // Input voltage alert threshold
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      input_voltage_alert_pct <= INPUT_ALERT_LOW_PCT;
    end
    else if (!hot_alert_option_zero[INPUT_VOLTAGE_ALERT_LOWER_ENABLE_BIT])
    begin
      input_voltage_alert_pct <= INPUT_ALERT_FOLLOW_PCT;
    end
    else if (hot_alert_option_zero[INPUT_VOLTAGE_ALERT_PCT_SELECT_BIT])
    begin
      input_voltage_alert_pct <= INPUT_ALERT_HIGH_PCT;
    end
    else
    begin
      input_voltage_alert_pct <= INPUT_ALERT_LOW_PCT;
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // A bit only changes once stages two and three agree, so a one-cycle glitch
  // is dropped at the cost of four cycles of latency.
  logic [1:0] pin_raw;
  logic [1:0] pin_stage_one;
  logic [1:0] pin_stage_two;
  logic [1:0] pin_stage_three;
  logic [1:0] pin_clean;
  logic cell_single_clean;
  logic assist_clean;

  assign pin_raw = {min_voltage_assist_mode, single_cell};

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_stage_one <= 2'h0;
      pin_stage_two <= 2'h0;
      pin_stage_three <= 2'h0;
    end
    else
    begin
      pin_stage_one <= pin_raw;
      pin_stage_two <= pin_stage_one;
      pin_stage_three <= pin_stage_two;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_clean <= 2'h0;
    end
    else
    begin
      pin_clean <= (pin_stage_two & pin_stage_three)
        | (pin_clean & (pin_stage_two | pin_stage_three));
    end
  end

  assign cell_single_clean = pin_clean[0];
  assign assist_clean = pin_clean[1];

  // ****************************************************************
  // System voltage threshold and input bus discharge
  // ****************************************************************
  logic [3:0] sys_code;
  logic [15:0] next_system_threshold_mv;
  logic sys_below;
  logic sys_below_qualified;

  assign sys_code =
    hot_alert_option_zero[SYSTEM_VOLTAGE_THRESHOLD_ONE_MSB:SYSTEM_VOLTAGE_THRESHOLD_ONE_LSB];

  // For a single cell the top code bit is ignored, so both halves repeat.
  always_comb
  begin
    if (cell_single_clean)
    begin
      next_system_threshold_mv = SYS_TH_SINGLE_CELL_BASE_MV
        + 16'(SYS_TH_STEP_MV * {13'h0000, sys_code[2:0]});
    end
    else
    begin
      next_system_threshold_mv = SYS_TH_MULTI_CELL_BASE_MV
        + 16'(SYS_TH_STEP_MV * {12'h000, sys_code});
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      system_threshold_mv <= SYS_TH_MULTI_CELL_BASE_MV;
      sys_below <= 1'b0;
    end
    else
    begin
      system_threshold_mv <= next_system_threshold_mv;
      sys_below <= system_voltage_mv < next_system_threshold_mv;
    end
  end

  deglitch_timer u_system_deglitch (
    .clk_sys(clk_sys),
    .rst(rst),
    .level(sys_below),
    .hold_cycles(DEGLITCH_COUNT_W'(SYS_TH_DEGLITCH_CYCLES)),
    .qualified(sys_below_qualified)
  );

  // Discharge is only meaningful while the assist mode is running.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      input_bus_discharge <= 1'b0;
    end
    else
    begin
      input_bus_discharge <= assist_clean && sys_below_qualified;
    end
  end

endmodule
`default_nettype wire

// file: design/charger_option_pkg.sv
// Constants, field layouts and carrier types for the charge option and
// processor-hot option register slice.
// Assumes a 50 MHz system clock and a byte-wide register access port.
package charger_option_pkg;

  // ****************************************************************
  // Byte addresses
  // ****************************************************************
  localparam logic [7:0] CHARGE_OPTION_THREE_LOW_ADDR = 8'h34;
  localparam logic [7:0] HOT_ALERT_OPTION_ZERO_LO_ADDR = 8'h36;
  localparam logic [7:0] HOT_ALERT_OPTION_ZERO_HI_ADDR = 8'h37;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] CHARGE_OPTION_THREE_LOW_RESET = 8'h30;
  localparam logic [15:0] HOT_ALERT_OPTION_ZERO_RESET = 16'h4a65;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CONSERVATIVE_ASSIST_ENABLE_BIT = 6;
  localparam int EXTERNAL_PIN_ROLE_SELECT_BIT = 5;
  localparam int INDUCTOR_AVG_CLAMP_MSB = 4;
  localparam int INDUCTOR_AVG_CLAMP_LSB = 3;
  localparam int REVERSE_SUPPLY_LOW_RANGE_BIT = 2;
  localparam int BATTERY_SWITCH_OFF_IN_HIGHZ_BIT = 1;
  localparam int POWER_MONITOR_SOURCE_SELECT_BIT = 0;
  localparam int SECONDARY_INPUT_LIMIT_MSB = 15;
  localparam int SECONDARY_INPUT_LIMIT_LSB = 11;
  localparam int CRITICAL_CURRENT_DEGLITCH_MSB = 10;
  localparam int CRITICAL_CURRENT_DEGLITCH_LSB = 9;
  localparam int INPUT_VOLTAGE_ALERT_PCT_SELECT_BIT = 8;
  localparam int SYSTEM_VOLTAGE_THRESHOLD_ONE_MSB = 7;
  localparam int SYSTEM_VOLTAGE_THRESHOLD_ONE_LSB = 4;
  localparam int INPUT_VOLTAGE_ALERT_LOWER_ENABLE_BIT = 0;

  // ****************************************************************
  // Encodings and scale figures
  // ****************************************************************
  localparam logic [4:0] LIMIT_FINE_LAST_CODE = 5'b11001;
  localparam logic [4:0] LIMIT_COARSE_FIRST_CODE = 5'b11010;
  localparam logic [4:0] LIMIT_OUT_OF_RANGE_CODE = 5'b11111;
  localparam logic [11:0] LIMIT_FINE_BASE_PCT = 12'd105;
  localparam logic [11:0] LIMIT_FINE_STEP_PCT = 12'd5;
  localparam logic [11:0] LIMIT_COARSE_BASE_PCT = 12'd250;
  localparam logic [11:0] LIMIT_COARSE_STEP_PCT = 12'd50;
  localparam logic [11:0] CRITICAL_NUM = 12'd11;
  localparam logic [11:0] CRITICAL_DEN = 12'd10;
  localparam logic [15:0] SYS_TH_MULTI_CELL_BASE_MV = 16'd5900;
  localparam logic [15:0] SYS_TH_SINGLE_CELL_BASE_MV = 16'd3100;
  localparam logic [15:0] SYS_TH_STEP_MV = 16'd100;
  localparam logic [6:0] INPUT_ALERT_FOLLOW_PCT = 7'd100;
  localparam logic [6:0] INPUT_ALERT_LOW_PCT = 7'd80;
  localparam logic [6:0] INPUT_ALERT_HIGH_PCT = 7'd90;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CRIT_DEG_15US_NS = 15000;
  localparam int CRIT_DEG_120US_NS = 120000;
  localparam int CRIT_DEG_500US_NS = 500000;
  localparam int CRIT_DEG_1MS_NS = 1000000;
  localparam int SYS_TH_DEGLITCH_NS = 5000;
  localparam int CRIT_DEG_15US_CYCLES = CRIT_DEG_15US_NS / CLK_PERIOD_NS;
  localparam int CRIT_DEG_120US_CYCLES = CRIT_DEG_120US_NS / CLK_PERIOD_NS;
  localparam int CRIT_DEG_500US_CYCLES = CRIT_DEG_500US_NS / CLK_PERIOD_NS;
  localparam int CRIT_DEG_1MS_CYCLES = CRIT_DEG_1MS_NS / CLK_PERIOD_NS;
  localparam int SYS_TH_DEGLITCH_CYCLES = SYS_TH_DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int DEGLITCH_COUNT_W = 16;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    CLAMP_6A,
    CLAMP_10A,
    CLAMP_15A,
    CLAMP_OFF
  } inductor_clamp_e;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic conservative_assist_enable;
    logic external_pin_role_select;
    inductor_clamp_e inductor_avg_clamp;
    logic reverse_supply_low_range;
    logic battery_switch_off_in_highz;
    logic power_monitor_source_select;
  } charge_cfg_s;

endpackage

// file: design/deglitch_timer.sv
// Holds a level for a programmable number of cycles before reporting it.
// Assumes the level and the count come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module deglitch_timer
  import charger_option_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic level,
  input wire logic [DEGLITCH_COUNT_W-1:0] hold_cycles,
  output logic qualified
);

  logic [DEGLITCH_COUNT_W-1:0] held;

  // A single drop of the level restarts the wait, so short glitches never pass.
  always_ff @(posedge clk_sys)
  begin
    if (rst || !level)
    begin
      held <= '0;
    end
    else if (held < hold_cycles)
    begin
      held <= held + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      qualified <= 1'b0;
    end
    else
    begin
      qualified <= level && (held >= hold_cycles - 1'b1);
    end
  end

endmodule
`default_nettype wire

// file: design/input_limit_decode.sv
// Turns the secondary input limit code into percentage thresholds.
// Assumes the code is a stable register output; the logic is combinational.
`timescale 1ns/100ps
`default_nettype none
module input_limit_decode
  import charger_option_pkg::*;
(
  input wire logic [4:0] code,
  output logic valid,
  output logic [11:0] limit_pct,
  output logic [11:0] critical_pct
);

  logic [11:0] code_w;
  logic [15:0] scaled;

  assign code_w = {7'h00, code};

  always_comb
  begin
    valid = 1'b1;
    limit_pct = '0;
    if (code == 5'h00 || code == LIMIT_OUT_OF_RANGE_CODE)
    begin
      valid = 1'b0;
    end
    else if (code <= LIMIT_FINE_LAST_CODE)
    begin
      limit_pct = LIMIT_FINE_BASE_PCT + LIMIT_FINE_STEP_PCT * code_w;
    end
    else
    begin
      limit_pct = LIMIT_COARSE_BASE_PCT
        + LIMIT_COARSE_STEP_PCT * (code_w - {7'h00, LIMIT_COARSE_FIRST_CODE});
    end
  end

  // The critical level is 110 percent of the secondary one, truncated.
  // The product is kept at sixteen bits since the top codes times eleven exceed twelve.
  assign scaled = 16'(limit_pct) * 16'(CRITICAL_NUM);
  assign critical_pct = 12'(scaled / 16'(CRITICAL_DEN));

endmodule
`default_nettype wire

// file: testbench/host_model.sv
// Host side of the byte register port, in place of the I2C engine.
// Assumes callers use only the two tasks, on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module host_model
  import charger_option_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  output var reg_req_s req
);
  // ****
  // Byte accesses
  // ****
  initial req = '0;

  // A request lasts one clock; released lines show the inverse of their last value.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req.addr = a;
    req.wdata = d;
    req.write = 1'b1;
    @(negedge clk_sys);
    req.write = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge clk_sys);
    req.addr = a;
    req.read = 1'b1;
    @(negedge clk_sys);
    req.read = 1'b0;
    req.addr = ~a;
    d = rdata;
    v = rvalid;
  endtask
endmodule
`default_nettype wire

// file: testbench/charger_option_hot_alert_regs_asserts.sv
// Timing checks on the ports of the option register slice.
// Assumes it is bound into the top module.
`timescale 1ns/100ps
`default_nettype none
module charger_option_hot_alert_regs_asserts
  import charger_option_pkg::*;
#(
  parameter int CRIT_DEG_120US = 6000,
  parameter int CRIT_DEG_500US = 25000,
  parameter int CRIT_DEG_1MS = 50000
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic min_voltage_assist_mode,
  input wire charge_cfg_s charge_cfg,
  input wire logic secondary_limit_trip,
  input wire logic critical_current_trip,
  input wire logic processor_hot_alert,
  input wire logic [6:0] input_voltage_alert_pct,
  input wire logic [15:0] system_threshold_mv,
  input wire logic input_bus_discharge
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_read_answered: assert property (req.read |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(req.read))
    else $error("answer without read");
  a_cfg_write: assert property (req.write && req.addr == 8'h34 |=>
    charge_cfg == 7'($past(req.wdata))) else $error("option byte not stored");
  a_cfg_hold: assert property (!(req.write && req.addr == 8'h34) |=> $stable(charge_cfg))
    else $error("option byte changed without write");
  a_crit_in_sec: assert property (critical_current_trip |-> secondary_limit_trip)
    else $error("critical trip below secondary");
  a_alert_cause: assert property ($rose(processor_hot_alert) |->
    $past(critical_current_trip) && $past(critical_current_trip, 16)) else $error("early alert");
  a_alert_drop: assert property ($fell(critical_current_trip) |=> !processor_hot_alert)
    else $error("alert outlived trip");
  a_follow_pct: assert property (req.write && req.addr == 8'h36 && !req.wdata[0] |->
    ##2 input_voltage_alert_pct == 7'h64) else $error("follow threshold wrong");
  a_sys_th_range: assert property (system_threshold_mv inside {[16'h0c1c:16'h1ce8]})
    else $error("threshold out of range");
  a_discharge_cause: assert property ($rose(input_bus_discharge) |->
    $past(min_voltage_assist_mode, 5)) else $error("discharge without assist");
  a_discharge_gate: assert property (!min_voltage_assist_mode [*6] |-> !input_bus_discharge)
    else $error("discharge outside assist");
  c_alert: cover property ($rose(processor_hot_alert));
  c_discharge: cover property ($rose(input_bus_discharge));
  c_read: cover property (rvalid && rdata == 8'h4a);
endmodule

bind charger_option_hot_alert_regs charger_option_hot_alert_regs_asserts #(
  .CRIT_DEG_120US(CRIT_DEG_120US), .CRIT_DEG_500US(CRIT_DEG_500US),
  .CRIT_DEG_1MS(CRIT_DEG_1MS)) chk (.clk_sys(clk_sys), .rst(rst), .req(req),
  .rdata(rdata), .rvalid(rvalid), .min_voltage_assist_mode(min_voltage_assist_mode),
  .charge_cfg(charge_cfg), .secondary_limit_trip(secondary_limit_trip),
  .critical_current_trip(critical_current_trip), .processor_hot_alert(processor_hot_alert),
  .input_voltage_alert_pct(input_voltage_alert_pct),
  .system_threshold_mv(system_threshold_mv), .input_bus_discharge(input_bus_discharge));
`default_nettype wire

// file: testbench/charger_option_hot_alert_regs_tb.sv
// Self-checking bench for the option register slice.
// Assumes the host model owns the register port; the bench drives the rest.
`timescale 1ns/100ps
`default_nettype none
module charger_option_hot_alert_regs_tb
  import charger_option_pkg::*;
;
  // Short deglitch counts keep the run brief.
  localparam int DEG1 = 32'h14;
  localparam int DEG2 = 32'h28;
  localparam int DEG3 = 32'h3c;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  logic [11:0] cur = 12'h000;
  logic [15:0] vsys = 16'h1c84;
  logic one_cell = 1'b0;
  logic assist = 1'b0;
  charge_cfg_s cfg;
  logic sec, crit, hot, dis;
  logic [6:0] vpct;
  logic [15:0] th;
  int fails = 0;
  int samples_checked = 0;

  charger_option_hot_alert_regs #(.CRIT_DEG_120US(DEG1), .CRIT_DEG_500US(DEG2),
    .CRIT_DEG_1MS(DEG3)) uut (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata),
    .rvalid(rvalid), .input_current_pct(cur), .system_voltage_mv(vsys),
    .single_cell(one_cell), .min_voltage_assist_mode(assist), .charge_cfg(cfg),
    .secondary_limit_trip(sec), .critical_current_trip(crit), .processor_hot_alert(hot),
    .input_voltage_alert_pct(vpct), .system_threshold_mv(th), .input_bus_discharge(dis));
  host_model host (.clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid), .req(req));

  initial forever #10 clk_sys = ~clk_sys;

  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    check(v, 1'b1);
    check(d, exp);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    rc(8'h34, 8'h30);
    rc(8'h36, 8'h65);
    rc(8'h37, 8'h4a);
    rc(8'h35, 8'h00);
    check(cfg, 16'h0030);
    check(vpct, 7'h50);
    check(th, 16'h1964);
    $display("reset values done");
  endtask

  task automatic t_cfg;
    logic [7:0] pat [4] = '{8'h80, 8'h4f, 8'h35, 8'hdb};
    foreach (pat[i])
    begin
      host.wr(8'h34, pat[i]);
      check(cfg, pat[i][6:0]);
      rc(8'h34, pat[i]);
    end
    rc(8'h37, 8'h4a);
    $display("option byte done");
  endtask

  task automatic t_vsys;
    logic [15:0] e;
    for (int c = 0; c < 32; c++)
    begin
      one_cell = c[4];
      host.wr(8'h36, {c[3:0], 4'h1});
      // The cell count pin takes four cycles through its synchroniser.
      cyc(3);
      e = c[4] ? 16'h0c1c + c[2:0] * 16'h64 : 16'h170c + c[3:0] * 16'h64;
      check(th, e);
    end
    host.wr(8'h36, 8'h00);
    cyc(2);
    check(vpct, 7'h64);
    host.wr(8'h37, 8'h4b);
    host.wr(8'h36, 8'h01);
    cyc(2);
    check(vpct, 7'h5a);
    rc(8'h37, 8'h4b);
    $display("system threshold done");
  endtask

  task automatic t_limit;
    logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h09, 5'h19, 5'h1a, 5'h1e, 5'h1f};
    logic [11:0] p;
    logic [11:0] k;
    logic ok;
    foreach (codes[i])
    begin
      host.wr(8'h37, {codes[i], 3'h0});
      ok = codes[i] != 5'h1f && codes[i] != 5'h00;
      p = codes[i] < 5'h1a ? 12'h06e + (codes[i] - 5'h01) * 12'h005
        : 12'h0fa + (codes[i] - 5'h1a) * 12'h032;
      k = 12'((16'(p) * 16'h000b) / 16'h000a);
      if (!ok)
      begin
        p = 12'hffe;
        k = 12'hffe;
      end
      cur = p;
      cyc(2);
      check(sec, 1'b0);
      cur = p + 1;
      cyc(2);
      check(sec, ok);
      cur = k;
      cyc(2);
      check(crit, 1'b0);
      cur = k + 1;
      cyc(2);
      check(crit, ok);
      cur = 12'h000;
    end
    $display("current limits done");
  endtask

  task automatic t_alert;
    int n [4] = '{CRIT_DEG_15US_CYCLES, DEG1, DEG2, DEG3};
    int t;
    for (int g = 0; g < 4; g++)
    begin
      host.wr(8'h37, {5'h09, g[1:0], 1'b0});
      cur = 12'h0c8;
      cyc(n[g] - 4);
      cur = 12'h000;
      cyc(3);
      check(hot, 1'b0);
      cur = 12'h0c8;
      t = 0;
      while (hot !== 1'b1 && t < 2000)
      begin
        cyc(1);
        t++;
      end
      check(t >= n[g] && t <= n[g] + 3, 1'b1);
      cur = 12'h000;
      cyc(2);
      check(hot, 1'b0);
    end
    $display("alert deglitch done");
  endtask

  task automatic t_discharge;
    int t;
    host.wr(8'h36, 8'h65);
    one_cell = 1'b0;
    vsys = 16'h1900;
    cyc(300);
    check(dis, 1'b0);
    assist = 1'b1;
    cyc(SYS_TH_DEGLITCH_CYCLES - 10);
    vsys = 16'h1c84;
    cyc(3);
    check(dis, 1'b0);
    vsys = 16'h1900;
    t = 0;
    while (dis !== 1'b1 && t < 1000)
    begin
      cyc(1);
      t++;
    end
    check(t >= 250 && t <= 254, 1'b1);
    assist = 1'b0;
    cyc(6);
    check(dis, 1'b0);
    $display("bus discharge done");
  endtask

  initial
  begin
    #400000;
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end

  initial
  begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    t_reset;
    t_cfg;
    t_vsys;
    t_limit;
    t_alert;
    t_discharge;
    host.wr(8'h34, 8'h00);
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rc(8'h34, 8'h30);
    test_done;
  end
endmodule
`default_nettype wire
